// *** rtl/trig_fabric_pkg.sv ***
// Constants shared by the trigger and synchronisation fabric.
// Assumes a single 20 MHz subsystem clock with per-domain clock enables.
package trig_fabric_pkg;
	localparam int NUM_ADC = 2;
	localparam int NUM_PWM = 4;
	localparam int NUM_START = 4;
	localparam int NUM_MATCH = 4;
	localparam int START_PIN = 0;
	localparam int START_PEER = 1;
	localparam int START_PWM = 2;
	localparam int START_TIMER = 3;
	localparam int PWM_MATCH_IDX = 3;
	localparam int SYNC_STAGES = 2;
	localparam logic EDGE_RISE = 1'b0;
	localparam logic EDGE_FALL = 1'b1;
	localparam logic [1:0] ST_IDLE = 2'h0;
	typedef enum logic [1:0] {
		SCHED_IDLE = 2'h0,
		SCHED_RUN = 2'h1,
		SCHED_PAUSE = 2'h3
	} sched_state_t;
endpackage

// *** rtl/pulse_sync.sv ***
// Two-flop synchroniser with rising-edge detector giving one pulse per edge.
// Assumes the destination domain is marked by i_dom_en on the common clock.
`timescale 1ns/1ns
module pulse_sync (
	// Clock, reset and enables
	input wire logic i_mclk,
	input wire logic i_resetn,
	input wire logic i_ce,
	input wire logic i_dom_en,
	// Level in, pulse out
	input wire logic i_level,
	output logic o_pulse
);
	import trig_fabric_pkg::*;
	logic meta;
	logic stable;
	logic last;

	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			meta <= 1'b0;
			stable <= 1'b0;
			last <= 1'b0;
			o_pulse <= 1'b0;
		end else if (i_ce) begin
			if (i_dom_en) begin
				meta <= i_level;
				stable <= meta;
				last <= stable;
				o_pulse <= stable & ~last; // [RQ16]
			end else begin
				o_pulse <= 1'b0;
			end
		end
	end

	single_pulse_a: assert property (@(posedge i_mclk) disable iff (!i_resetn)
		o_pulse |=> !o_pulse) else $error("pulse longer than one cycle"); // [RQ16]
endmodule

// *** rtl/trig_fabric.sv ***
// Trigger routing and sync cascade between the ADC, PWM and timer blocks.
// Assumes all domain clocks are modelled as enables of i_mclk.
`timescale 1ns/1ns

// How it works
// RQ1 - Each ADC has four start inputs; any valid one starts a conversion.
// RQ2 - Start 0 is the external pin, rising or falling edge, ADC domain.
// RQ3 - Start 1 is the other ADC's end-of-conversion, subsystem domain.
// RQ4 - Start 2 is PWM sync, captured in subsystem domain.
// RQ5 - Start 3 is scheduling timer match, ADC domain.
// RQ6 - Timer fourth match drives PWM 0 sync and transfer enable.
// RQ7 - Sync passes through each PWM with its own programmable delay.
// RQ8 - Cascade order fixed: PWM n drives PWM n+1.
// RQ9 - Carrier timer matches drive the PWM carrier inputs.
// RQ10 - Carrier pause pin stops carrier generation while asserted.
// RQ11 - Scheduling timer pause is NOR of PWM syncs; counts while any high.
// RQ12 - Software enables pause, loads N, enables start 3 for every-N sampling.
// RQ13 - Timer captures see ADC start pulses, for debugging.
// RQ14 - ADC splits into bus part and converter part on separate clocks.
// RQ15 - Unused PWM or ADC clock branches gate off independently.
// RQ16 - Each crossing uses a two-flop synchroniser giving one pulse.
module trig_fabric (
	// Clock, reset, enable
	input wire logic i_mclk,
	input wire logic i_resetn,
	input wire logic i_ce,
	// Clock branch enables
	input wire logic [trig_fabric_pkg::NUM_ADC-1:0] i_adc_conv_en,
	input wire logic [trig_fabric_pkg::NUM_ADC-1:0] i_adc_bus_en,
	input wire logic [trig_fabric_pkg::NUM_PWM-1:0] i_pwm_clk_en,
	// ADC side
	input wire logic [trig_fabric_pkg::NUM_ADC-1:0] i_adc_pin,
	input wire logic [trig_fabric_pkg::NUM_ADC-1:0] i_adc_pin_edge,
	input wire logic [trig_fabric_pkg::NUM_ADC-1:0] i_adc_eoc,
	input wire logic [trig_fabric_pkg::NUM_START*trig_fabric_pkg::NUM_ADC-1:0] i_start_en,
	output logic [trig_fabric_pkg::NUM_START*trig_fabric_pkg::NUM_ADC-1:0] o_start_pulse,
	output logic [trig_fabric_pkg::NUM_ADC-1:0] o_adc_start,
	// PWM side
	input wire logic [trig_fabric_pkg::NUM_PWM-1:0] i_pwm_sync,
	output logic [trig_fabric_pkg::NUM_PWM-1:0] o_pwm_sync_in,
	output logic [trig_fabric_pkg::NUM_PWM-1:0] o_pwm_trans_en,
	output logic [trig_fabric_pkg::NUM_PWM-1:0] o_pwm_carrier,
	// Scheduling timer
	input wire logic [trig_fabric_pkg::NUM_MATCH-1:0] i_sched_match,
	input wire logic i_sched_pause_en,
	output logic o_sched_pause,
	output logic o_sched_count,
	output logic [trig_fabric_pkg::NUM_ADC-1:0] o_sched_capture,
	// Carrier timer
	input wire logic [trig_fabric_pkg::NUM_PWM-1:0] i_carrier_match,
	input wire logic i_carrier_pause_pin,
	output logic o_carrier_pause,
	output logic [trig_fabric_pkg::NUM_ADC-1:0] o_carrier_capture
);
	import trig_fabric_pkg::*;

	logic [NUM_ADC-1:0] pin_level;
	logic [NUM_ADC-1:0] pin_pulse;
	logic [NUM_ADC-1:0] peer_pulse;
	logic [NUM_ADC-1:0] pwm_pulse;
	logic [NUM_ADC-1:0] tmr_pulse;
	logic [NUM_ADC-1:0] next_start;
	logic any_sync;
	sched_state_t sched_state;

	function automatic logic start_any(input logic [NUM_START-1:0] pulses,
		input logic [NUM_START-1:0] en);
		start_any = |(pulses & en);
	endfunction

	assign any_sync = |i_pwm_sync;

	genvar a;
	generate
		for (a = 0; a < NUM_ADC; a++) begin : g_adc
			// Edge polarity select: falling is a rising edge of the inverted pin
			assign pin_level[a] = (i_adc_pin_edge[a] == EDGE_FALL) ? ~i_adc_pin[a] :
				i_adc_pin[a]; // [RQ2]
			pulse_sync u_pin (
				.i_mclk(i_mclk),
				.i_resetn(i_resetn),
				.i_ce(i_ce),
				.i_dom_en(i_adc_conv_en[a]), // [RQ2] [RQ14]
				.i_level(pin_level[a]),
				.o_pulse(pin_pulse[a])
			);
			pulse_sync u_peer (
				.i_mclk(i_mclk),
				.i_resetn(i_resetn),
				.i_ce(i_ce),
				.i_dom_en(i_adc_bus_en[a]),
				.i_level(i_adc_eoc[NUM_ADC-1-a]), // [RQ3]
				.o_pulse(peer_pulse[a])
			);
			pulse_sync u_pwm (
				.i_mclk(i_mclk),
				.i_resetn(i_resetn),
				.i_ce(i_ce),
				.i_dom_en(i_adc_bus_en[a]),
				.i_level(any_sync), // [RQ4]
				.o_pulse(pwm_pulse[a])
			);
			pulse_sync u_tmr (
				.i_mclk(i_mclk),
				.i_resetn(i_resetn),
				.i_ce(i_ce),
				.i_dom_en(i_adc_conv_en[a]), // [RQ5]
				.i_level(|i_sched_match),
				.o_pulse(tmr_pulse[a])
			);
			assign next_start[a] = start_any({tmr_pulse[a], pwm_pulse[a], peer_pulse[a],
				pin_pulse[a]}, i_start_en[a*NUM_START +: NUM_START]); // [RQ1]
		end
	endgenerate

	// Start pulses and conversion request per ADC
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_start_pulse <= '0;
			o_adc_start <= '0;
		end else if (i_ce) begin
			for (int k = 0; k < NUM_ADC; k++) begin
				o_start_pulse[k*NUM_START + START_PIN] <= pin_pulse[k];
				o_start_pulse[k*NUM_START + START_PEER] <= peer_pulse[k];
				o_start_pulse[k*NUM_START + START_PWM] <= pwm_pulse[k];
				o_start_pulse[k*NUM_START + START_TIMER] <= tmr_pulse[k];
			end
			o_adc_start <= next_start; // [RQ1]
		end
	end

	// Debug capture of ADC starts on both timers
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_sched_capture <= '0;
			o_carrier_capture <= '0;
		end else if (i_ce) begin
			o_sched_capture <= next_start; // [RQ13]
			o_carrier_capture <= next_start; // [RQ13]
		end
	end

	// Sync cascade: the timer starts PWM 0, each PWM then starts the next
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_pwm_sync_in <= '0;
			o_pwm_trans_en <= '0;
		end else if (i_ce) begin
			for (int p = 0; p < NUM_PWM; p++) begin
				if (!i_pwm_clk_en[p]) begin
					o_pwm_sync_in[p] <= 1'b0; // [RQ15]
					o_pwm_trans_en[p] <= 1'b0;
				end else if (p == 0) begin
					o_pwm_sync_in[p] <= i_sched_match[PWM_MATCH_IDX]; // [RQ6]
					o_pwm_trans_en[p] <= i_sched_match[PWM_MATCH_IDX]; // [RQ6]
				end else begin
					// Delay is applied inside the PWM; here only the chain order
					o_pwm_sync_in[p] <= i_pwm_sync[p-1]; // [RQ7] [RQ8]
					o_pwm_trans_en[p] <= i_pwm_sync[p-1]; // [RQ8]
				end
			end
		end
	end

	// Carrier patterns and pin-driven pause
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_pwm_carrier <= '0;
			o_carrier_pause <= 1'b0;
		end else if (i_ce) begin
			o_carrier_pause <= i_carrier_pause_pin; // [RQ10]
			o_pwm_carrier <= i_carrier_pause_pin ? '0 : (i_carrier_match & i_pwm_clk_en); // [RQ9] [RQ10]
		end
	end

	// Scheduling timer pause: NOR of PWM syncs; its enable gates only the count stop
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			sched_state <= SCHED_IDLE;
			o_sched_pause <= 1'b0;
			o_sched_count <= 1'b0;
		end else if (i_ce) begin
			o_sched_pause <= ~any_sync; // [RQ11]
			case (sched_state)
				SCHED_IDLE: begin
					sched_state <= SCHED_RUN;
					o_sched_count <= 1'b1;
				end
				SCHED_RUN: begin
					if (i_sched_pause_en && !any_sync) begin
						sched_state <= SCHED_PAUSE;
						o_sched_count <= 1'b0; // [RQ11]
					end else begin
						o_sched_count <= 1'b1;
					end
				end
				SCHED_PAUSE: begin
					if (!i_sched_pause_en || any_sync) begin
						sched_state <= SCHED_RUN;
						o_sched_count <= 1'b1; // [RQ11] [RQ12]
					end else begin
						o_sched_count <= 1'b0;
					end
				end
				default: begin
					sched_state <= SCHED_IDLE;
					o_sched_count <= 1'b0;
				end
			endcase
		end
	end

	// Conversion requests
	start_or_a: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [RQ1]
		i_ce && |next_start |=> o_adc_start == $past(next_start))
		else $error("start request lost");
	start_mask_a: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [RQ1]
		i_ce && !(|next_start) |=> o_adc_start == '0)
		else $error("start without enabled source");

	// Each start source lands in its own pulse bit
	pin0_record_a: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [RQ2]
		i_ce && pin_pulse[0] |=> o_start_pulse[START_PIN])
		else $error("pin start of first ADC not recorded");
	pin1_record_a: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [RQ2]
		i_ce && pin_pulse[1] |=> o_start_pulse[NUM_START + START_PIN])
		else $error("pin start of second ADC not recorded");
	peer_cross_a: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [RQ3]
		i_ce && peer_pulse[0] |=> o_start_pulse[START_PEER])
		else $error("peer start not recorded");
	peer1_cross_a: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [RQ3]
		i_ce && peer_pulse[1] |=> o_start_pulse[NUM_START + START_PEER])
		else $error("peer start of second ADC not recorded");
	pwm0_record_a: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [RQ4]
		i_ce && pwm_pulse[0] |=> o_start_pulse[START_PWM])
		else $error("PWM start of first ADC not recorded");
	pwm1_record_a: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [RQ4]
		i_ce && pwm_pulse[1] |=> o_start_pulse[NUM_START + START_PWM])
		else $error("PWM start of second ADC not recorded");
	tmr0_record_a: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [RQ5]
		i_ce && tmr_pulse[0] |=> o_start_pulse[START_TIMER])
		else $error("timer start of first ADC not recorded");
	tmr1_record_a: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [RQ5]
		i_ce && tmr_pulse[1] |=> o_start_pulse[NUM_START + START_TIMER])
		else $error("timer start of second ADC not recorded");

	// Sync cascade
	pwm0_sync_a: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [RQ6]
		i_ce && i_pwm_clk_en[0] |=> o_pwm_sync_in[0] == $past(i_sched_match[PWM_MATCH_IDX]))
		else $error("PWM 0 sync not from fourth match");
	trans_en0_a: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [RQ6]
		i_ce && i_pwm_clk_en[0] |=> o_pwm_trans_en[0] == $past(i_sched_match[PWM_MATCH_IDX]))
		else $error("PWM 0 transfer enable not from fourth match");
	chain_sync1_a: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [RQ8]
		i_ce && i_pwm_clk_en[1] |=> o_pwm_sync_in[1] == $past(i_pwm_sync[0]))
		else $error("PWM 1 sync not from PWM 0");
	chain_order_a: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [RQ8]
		i_ce && i_pwm_clk_en[2] |=> o_pwm_sync_in[2] == $past(i_pwm_sync[1]))
		else $error("cascade out of order");
	chain_sync3_a: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [RQ7]
		i_ce && i_pwm_clk_en[3] |=> o_pwm_sync_in[3] == $past(i_pwm_sync[2]))
		else $error("PWM 3 sync not from PWM 2");
	chain_trans1_a: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [RQ8]
		i_ce && i_pwm_clk_en[1] |=> o_pwm_trans_en[1] == $past(i_pwm_sync[0]))
		else $error("PWM 1 transfer enable not from PWM 0");
	chain_trans2_a: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [RQ8]
		i_ce && i_pwm_clk_en[2] |=> o_pwm_trans_en[2] == $past(i_pwm_sync[1]))
		else $error("PWM 2 transfer enable not from PWM 1");
	chain_trans3_a: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [RQ8]
		i_ce && i_pwm_clk_en[3] |=> o_pwm_trans_en[3] == $past(i_pwm_sync[2]))
		else $error("PWM 3 transfer enable not from PWM 2");

	// Carrier timer
	carrier_pause_a: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [RQ10]
		i_ce && i_carrier_pause_pin |=> o_pwm_carrier == '0 && o_carrier_pause)
		else $error("carrier runs during pause");
	carrier_copy_a: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [RQ10]
		i_ce |=> o_carrier_pause == $past(i_carrier_pause_pin))
		else $error("carrier pause not following its pin");
	carrier_route_a: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [RQ9]
		i_ce && !i_carrier_pause_pin |=> o_pwm_carrier == $past(i_carrier_match & i_pwm_clk_en))
		else $error("carrier misrouted");

	// Scheduling timer pause
	sched_pause_a: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [RQ11]
		i_ce && sched_state == SCHED_RUN && i_sched_pause_en && !any_sync |=> !o_sched_count)
		else $error("timer counts during pause");
	sched_run_a: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [RQ11]
		i_ce && sched_state == SCHED_RUN && !(i_sched_pause_en && !any_sync) |=> o_sched_count)
		else $error("timer stopped while running");
	sched_resume_a: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [RQ11]
		i_ce && sched_state == SCHED_PAUSE && (!i_sched_pause_en || any_sync) |=> o_sched_count)
		else $error("timer did not resume");
	sched_nor_a: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [RQ11]
		i_ce |=> o_sched_pause == !$past(any_sync))
		else $error("pause input is not the NOR of PWM syncs");

	// Clock branch gating
	gate_off_a: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [RQ15]
		i_ce && !i_pwm_clk_en[1] |=> !o_pwm_sync_in[1] && !o_pwm_trans_en[1])
		else $error("gated PWM still driven");
	gate_pwm0_a: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [RQ15]
		i_ce && !i_pwm_clk_en[0] |=> !o_pwm_sync_in[0] && !o_pwm_trans_en[0])
		else $error("gated PWM 0 still driven");
	gate_pwm3_a: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [RQ15]
		i_ce && !i_pwm_clk_en[3] |=> !o_pwm_sync_in[3] && !o_pwm_trans_en[3] && !o_pwm_carrier[3])
		else $error("gated PWM 3 still driven");

	// Debug captures
	debug_cap_a: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [RQ13]
		i_ce |=> o_sched_capture == $past(next_start))
		else $error("capture differs from start");
	carrier_cap_a: assert property (@(posedge i_mclk) disable iff (!i_resetn) // [RQ13]
		i_ce |=> o_carrier_capture == $past(next_start))
		else $error("carrier timer capture differs from start");
endmodule

// *** testbench/adc_eoc_model.sv ***
// Behavioural model of the two ADCs as seen by the trigger fabric.
// Assumes one conversion request pulse per start; answers with end-of-conversion.
`timescale 1ns/1ns
module adc_eoc_model (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_resetn,
	// Requests in, end of conversion out
	input wire logic [1:0] i_start,
	output logic [1:0] o_eoc
);
	logic [2:0] conv_cnt [2];

	// A short conversion, then end-of-conversion high for two cycles
	always @(posedge i_mclk or negedge i_resetn) begin
		for (int a = 0; a < 2; a++) begin
			if (!i_resetn)
				conv_cnt[a] <= 3'h0;
			else if (i_start[a])
				conv_cnt[a] <= 3'h5;
			else if (conv_cnt[a] != 3'h0)
				conv_cnt[a] <= conv_cnt[a] - 3'h1;
		end
	end
	assign o_eoc[0] = (conv_cnt[0] == 3'h2) || (conv_cnt[0] == 3'h1);
	assign o_eoc[1] = (conv_cnt[1] == 3'h2) || (conv_cnt[1] == 3'h1);
endmodule

// *** testbench/adc_pwm_trigger_sync_fabric_bench.sv ***
// Self-checking bench for the trigger routing and sync cascade.
// Assumes the ADC model closes the end-of-conversion loop between the ADCs.
`timescale 1ns/1ns
module adc_pwm_trigger_sync_fabric_bench;
	logic i_mclk = 0, i_resetn = 0;
	logic [1:0] pin = 0, pin_edge = 0, eoc;
	logic [7:0] start_en = 0, o_start_pulse;
	logic [1:0] o_adc_start, o_sched_capture, o_carrier_capture;
	logic [3:0] pwm_sync = 0, sched_match = 0, carrier_match = 0, clk_en = 4'hF;
	logic [3:0] o_pwm_sync_in, o_pwm_trans_en, o_pwm_carrier;
	logic pause_en = 0, pause_pin = 0, o_sched_pause, o_sched_count, o_carrier_pause;
	int n_errors = 0, samples_checked = 0, cycles = 0;

	trig_fabric i_trig_fabric (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_ce(1'b1),
		.i_adc_conv_en(2'h3), .i_adc_bus_en(2'h3), .i_pwm_clk_en(clk_en),
		.i_adc_pin(pin), .i_adc_pin_edge(pin_edge), .i_adc_eoc(eoc),
		.i_start_en(start_en), .o_start_pulse(o_start_pulse), .o_adc_start(o_adc_start),
		.i_pwm_sync(pwm_sync), .o_pwm_sync_in(o_pwm_sync_in),
		.o_pwm_trans_en(o_pwm_trans_en), .o_pwm_carrier(o_pwm_carrier),
		.i_sched_match(sched_match), .i_sched_pause_en(pause_en),
		.o_sched_pause(o_sched_pause), .o_sched_count(o_sched_count),
		.o_sched_capture(o_sched_capture), .i_carrier_match(carrier_match),
		.i_carrier_pause_pin(pause_pin), .o_carrier_pause(o_carrier_pause),
		.o_carrier_capture(o_carrier_capture));
	adc_eoc_model i_adc_eoc_model (.i_mclk(i_mclk), .i_resetn(i_resetn),
		.i_start(o_adc_start), .o_eoc(eoc));

	initial begin
		forever #25 i_mclk = ~i_mclk;
	end

	always @(posedge i_mclk) begin
		cycles++;
		if (cycles == 1000) begin
			n_errors++;
			final_report;
		end
	end

	task final_report;
		$display("checked=%0d errors=%0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Watch 24 cycles from the stimulus negedge and judge the start traffic
	task watch(input logic [7:0] e_sp, input logic [1:0] e_as, input logic [7:0] e_cnt);
		logic [7:0] sp, first, cnt;
		logic [1:0] as, cap;
		sp = 0; as = 0; cap = 0; first = 0; cnt = 0;
		for (int k = 1; k <= 24; k++) begin
			@(negedge i_mclk);
			sp |= o_start_pulse;
			as |= o_adc_start;
			cap |= o_sched_capture | o_carrier_capture;
			if (o_adc_start != 2'h0) cnt++;
			if (first == 0 && o_adc_start != 2'h0) first = 8'(k);
		end
		chk(sp, e_sp);
		chk({6'h0, as}, {6'h0, e_as});
		chk({6'h0, cap}, {6'h0, e_as});
		chk(first, 8'h04);
		chk(cnt, e_cnt);
	endtask

	task pin_rise;
		@(negedge i_mclk);
		start_en = 8'h21;
		pin = 2'b01;
		watch(8'h23, 2'b11, 8'h02);
		pin = 2'b00;
	endtask

	task pin_fall;
		start_en = 8'h10;
		pin_edge = 2'b10;
		pin = 2'b10;
		repeat (6) @(negedge i_mclk);
		pin = 2'b00;
		watch(8'h12, 2'b10, 8'h01);
	endtask

	task pwm_start;
		start_en = 8'h04;
		pwm_sync = 4'b0001;
		watch(8'h64, 2'b01, 8'h01);
		pwm_sync = 4'h0;
	endtask

	task timer_start;
		start_en = 8'h80;
		sched_match = 4'b0001;
		watch(8'h8A, 2'b10, 8'h01);
		sched_match = 4'h0;
	endtask

	task cascade;
		start_en = 8'h00;
		pause_en = 1'b1;
		pwm_sync = 4'b0101;
		sched_match = 4'b1000;
		carrier_match = 4'hF;
		repeat (3) @(negedge i_mclk);
		chk({4'h0, o_pwm_sync_in}, 8'h0B);
		chk({4'h0, o_pwm_trans_en}, 8'h0B);
		chk({4'h0, o_pwm_carrier}, 8'h0F);
		chk({6'h0, o_sched_pause, o_sched_count}, 8'h01);
		clk_en = 4'b1110;
		pause_pin = 1'b1;
		pwm_sync = 4'h0;
		repeat (3) @(negedge i_mclk);
		chk({4'h0, o_pwm_carrier}, 8'h00);
		chk({7'h0, o_carrier_pause}, 8'h01);
		chk({6'h0, o_sched_pause, o_sched_count}, 8'h02);
		pause_pin = 1'b0;
		repeat (2) @(negedge i_mclk);
		chk({4'h0, o_pwm_carrier}, 8'h0E);
		chk({7'h0, o_pwm_sync_in[0]}, 8'h00);
		sched_match = 4'h0;
	endtask

	initial begin
		repeat (5) @(negedge i_mclk);
		i_resetn = 1'b1;
		repeat (4) @(negedge i_mclk);
		pin_rise;
		pin_fall;
		pwm_start;
		timer_start;
		cascade;
		final_report;
	end
endmodule
